/* shared/uefc_pkg.sv */
// Shared constants, types and helpers for the external power fault controller
package uefc_pkg;

   // ==========================================================
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BE_W   = 4;

   // ==========================================================
   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_EXT_POWER_CONTROL = 12'h400;
   localparam logic [ADDR_W-1:0] OFS_FAULT_RAW_STATUS  = 12'h404;
   localparam logic [ADDR_W-1:0] OFS_FAULT_IRQ_MASK    = 12'h408;
   localparam logic [ADDR_W-1:0] OFS_FAULT_IRQ_CLEAR   = 12'h40c;

   // ==========================================================
   // Control register field positions, and the fault bit of the status, mask and clear registers
   localparam int unsigned LEVEL_LSB         = 0;
   localparam int unsigned DRIVE_EN_BIT      = 2;
   localparam int unsigned FAULT_IN_EN_BIT   = 4;
   localparam int unsigned FAULT_SENSE_BIT   = 5;
   localparam int unsigned FAULT_ACT_EN_BIT  = 6;
   localparam int unsigned FAULT_ACT_SEL_LSB = 8;
   localparam int unsigned POWER_FAULT_BIT   = 0;

   // ==========================================================
   // Field encodings
   localparam logic [1:0] ACT_UNCHANGED   = 2'h0;
   localparam logic [1:0] ACT_TRISTATE    = 2'h1;
   localparam logic [1:0] ACT_DRIVE_LOW   = 2'h2;
   localparam logic [1:0] ACT_DRIVE_HIGH  = 2'h3;
   localparam logic [1:0] LVL_ACTIVE_LOW  = 2'h0;
   localparam logic [1:0] LVL_ACTIVE_HIGH = 2'h1;

   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] CTRL_RESET  = 32'h0000_0000;
   localparam logic              FLAG_RESET  = 1'b0;
   localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0]   byteenable;
   } uefc_avl_req_t;

   typedef struct packed {
      logic [1:0] fault_action_select;
      logic       fault_action_enable;
      logic       fault_sense_polarity;
      logic       fault_input_enable;
      logic       supply_enable_drive_enable;
      logic [1:0] supply_enable_level;
   } uefc_ctrl_t;

   // ==========================================================
   // Byte-lane merge of write data into an old word
   function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_w,
                                                 input logic [DATA_W-1:0] new_w,
                                                 input logic [BE_W-1:0]   be);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

endpackage : uefc_pkg

/* hdl/uefc_avl_slave.sv */
// Avalon-MM slave handshake: one wait cycle, registered read data
`timescale 1ns/1ns
module uefc_avl_slave (
   input  wire logic                          clk_in,
   input  wire logic                          sys_rst_in,
   input  wire uefc_pkg::uefc_avl_req_t       req_in,
   input  wire logic [uefc_pkg::DATA_W-1:0]   rdata_in,
   output logic                               waitrequest_out,
   output logic [uefc_pkg::DATA_W-1:0]        readdata_out,
   output logic                               wr_commit_out
);

   typedef enum logic {SL_IDLE, SL_ANSWER} uefc_sl_state_t;

   uefc_sl_state_t state_r;
   logic           active;

   assign active = req_in.read | req_in.write;

   // Write lands only at the edge where the master sees waitrequest low
   assign wr_commit_out = req_in.write & (state_r == SL_ANSWER);

   // ==========================================================
   // Handshake sequencer
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_r         <= SL_IDLE;
         waitrequest_out <= 1'b1;
      end else begin
         case (state_r)
            SL_IDLE: begin
               if (active) begin
                  state_r         <= SL_ANSWER;
                  waitrequest_out <= 1'b0;
               end
            end
            SL_ANSWER: begin
               // Back to waiting so each request sees a fresh wait cycle
               state_r         <= SL_IDLE;
               waitrequest_out <= 1'b1;
            end
            default: begin
               state_r         <= SL_IDLE;
               waitrequest_out <= 1'b1;
            end
         endcase
      end
   end

   // Read data captured as waitrequest drops, stable at the sampling edge
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         readdata_out <= uefc_pkg::UNMAPPED_RD;
      end else if (state_r == SL_IDLE && req_in.read) begin
         readdata_out <= rdata_in;
      end
   end

endmodule : uefc_avl_slave

/* hdl/uefc_fault_sense.sv */
// Fault input synchroniser and polarity / enable qualification
`timescale 1ns/1ns
module uefc_fault_sense (
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic ext_power_fault_in,
   input  wire logic fault_input_enable_in,
   input  wire logic fault_sense_polarity_in,
   output logic      fault_now_out
);

   logic meta_r;
   logic sync_r;

   // ==========================================================
   // Two-stage synchroniser; first stage read only by the second
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= ext_power_fault_in;
         sync_r <= meta_r;
      end
   end

   // Fault only when enabled and level matches selected sense
   assign fault_now_out = fault_input_enable_in
                          & (sync_r == fault_sense_polarity_in);

endmodule : uefc_fault_sense

/* hdl/uefc_top.sv */
// External USB power enable / power fault controller with Avalon-MM registers
`timescale 1ns/1ns
module uefc_top (
   input  wire logic                          clk_in,
   input  wire logic                          sys_rst_in,
   // Avalon-MM slave
   input  wire logic [uefc_pkg::ADDR_W-1:0]   avs_address_in,
   input  wire logic                          avs_read_in,
   input  wire logic                          avs_write_in,
   input  wire logic [uefc_pkg::DATA_W-1:0]   avs_writedata_in,
   input  wire logic [uefc_pkg::BE_W-1:0]     avs_byteenable_in,
   output logic [uefc_pkg::DATA_W-1:0]        avs_readdata_out,
   output logic                               avs_waitrequest_out,
   // External power interface
   input  wire logic                          ext_power_fault_in,
   output logic                               ext_power_enable_out,
   output logic                               ext_power_enable_oe_out,
   // Interrupt
   output logic                               irq_out
);

   // ==========================================================
   // Declarations
   uefc_pkg::uefc_avl_req_t         req;
   uefc_pkg::uefc_ctrl_t            ctrl_r;
   logic [uefc_pkg::DATA_W-1:0]     ctrl_word;
   logic [uefc_pkg::DATA_W-1:0]     ctrl_word_nxt;
   logic [uefc_pkg::DATA_W-1:0]     mask_word_nxt;
   logic [uefc_pkg::DATA_W-1:0]     rdata;
   logic                            wr_commit;
   logic                            fault_now;
   logic                            fault_flag_r;
   logic                            fault_mask_r;
   logic                            clear_hit;
   logic                            forced;
   logic                            pin_val_nxt;
   logic                            pin_oe_nxt;

   // ==========================================================
   // Write decode shared by every writable or clearable word
   function automatic logic reg_hit(input logic                        commit,
                                    input logic [uefc_pkg::ADDR_W-1:0] addr,
                                    input logic [uefc_pkg::ADDR_W-1:0] ofs);
      return commit && (addr == ofs);
   endfunction : reg_hit

   // Bus request bundled for the handshake module
   assign req.address    = avs_address_in;
   assign req.read       = avs_read_in;
   assign req.write      = avs_write_in;
   assign req.writedata  = avs_writedata_in;
   assign req.byteenable = avs_byteenable_in;

   // ==========================================================
   // Bus handshake
   uefc_avl_slave u_slave (
      .clk_in          (clk_in),
      .sys_rst_in      (sys_rst_in),
      .req_in          (req),
      .rdata_in        (rdata),
      .waitrequest_out (avs_waitrequest_out),
      .readdata_out    (avs_readdata_out),
      .wr_commit_out   (wr_commit)
   );

   // ==========================================================
   // Fault input path
   uefc_fault_sense u_sense (
      .clk_in                  (clk_in),
      .sys_rst_in              (sys_rst_in),
      .ext_power_fault_in      (ext_power_fault_in),
      .fault_input_enable_in   (ctrl_r.fault_input_enable),
      .fault_sense_polarity_in (ctrl_r.fault_sense_polarity),
      .fault_now_out           (fault_now)
   );

   // ==========================================================
   // Control word view; reserved bits including bit 3 read as zero
   always_comb begin
      ctrl_word = '0;
      ctrl_word[uefc_pkg::LEVEL_LSB +: 2]         = ctrl_r.supply_enable_level;
      ctrl_word[uefc_pkg::DRIVE_EN_BIT]           = ctrl_r.supply_enable_drive_enable;
      ctrl_word[uefc_pkg::FAULT_IN_EN_BIT]        = ctrl_r.fault_input_enable;
      ctrl_word[uefc_pkg::FAULT_SENSE_BIT]        = ctrl_r.fault_sense_polarity;
      ctrl_word[uefc_pkg::FAULT_ACT_EN_BIT]       = ctrl_r.fault_action_enable;
      ctrl_word[uefc_pkg::FAULT_ACT_SEL_LSB +: 2] = ctrl_r.fault_action_select;
   end

   // Byte-lane merges for the two writable words
   assign ctrl_word_nxt = uefc_pkg::be_merge(ctrl_word, req.writedata, req.byteenable);
   assign mask_word_nxt = uefc_pkg::be_merge({{(uefc_pkg::DATA_W-1){1'b0}}, fault_mask_r},
                                             req.writedata, req.byteenable);

   // ==========================================================
   // Control register; reserved bit 3 has no storage, so writes to it are dropped
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_r <= uefc_pkg::uefc_ctrl_t'(uefc_pkg::CTRL_RESET[$bits(uefc_pkg::uefc_ctrl_t)-1:0]);
      end else if (reg_hit(wr_commit, req.address, uefc_pkg::OFS_EXT_POWER_CONTROL)) begin
         ctrl_r.supply_enable_level        <= ctrl_word_nxt[uefc_pkg::LEVEL_LSB +: 2];
         ctrl_r.supply_enable_drive_enable <= ctrl_word_nxt[uefc_pkg::DRIVE_EN_BIT];
         ctrl_r.fault_input_enable         <= ctrl_word_nxt[uefc_pkg::FAULT_IN_EN_BIT];
         ctrl_r.fault_sense_polarity       <= ctrl_word_nxt[uefc_pkg::FAULT_SENSE_BIT];
         ctrl_r.fault_action_enable        <= ctrl_word_nxt[uefc_pkg::FAULT_ACT_EN_BIT];
         ctrl_r.fault_action_select        <= ctrl_word_nxt[uefc_pkg::FAULT_ACT_SEL_LSB +: 2];
      end
   end

   // ==========================================================
   // Interrupt mask register
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         fault_mask_r <= uefc_pkg::FLAG_RESET;
      end else if (reg_hit(wr_commit, req.address, uefc_pkg::OFS_FAULT_IRQ_MASK)) begin
         fault_mask_r <= mask_word_nxt[uefc_pkg::POWER_FAULT_BIT];
      end
   end

   // Write-one-to-clear on the low byte lane of the clear register
   assign clear_hit = reg_hit(wr_commit, req.address, uefc_pkg::OFS_FAULT_IRQ_CLEAR)
                      && req.byteenable[0]
                      && req.writedata[uefc_pkg::POWER_FAULT_BIT];

   // ==========================================================
   // Sticky fault flag; a fault in the clear cycle wins so none is lost
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         fault_flag_r <= uefc_pkg::FLAG_RESET;
      end else if (fault_now) begin
         fault_flag_r <= 1'b1;
      end else if (clear_hit) begin
         fault_flag_r <= 1'b0;
      end
   end

   // Level interrupt, registered so the pin comes from a flop
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= fault_flag_r & fault_mask_r;
      end
   end

   // ==========================================================
   // Enable pin next state
   // Forced state holds while the sticky flag stands, so a bouncing
   // fault input cannot re-enable the supply before software has looked.
   assign forced = ctrl_r.fault_action_enable && fault_flag_r
                   && ctrl_r.fault_action_select != uefc_pkg::ACT_UNCHANGED;

   always_comb begin
      pin_val_nxt = 1'b0;
      pin_oe_nxt  = 1'b0;
      if (forced) begin
         case (ctrl_r.fault_action_select)
            uefc_pkg::ACT_TRISTATE: begin
               pin_oe_nxt = 1'b0;
            end
            uefc_pkg::ACT_DRIVE_LOW: begin
               pin_oe_nxt  = 1'b1;
               pin_val_nxt = 1'b0;
            end
            uefc_pkg::ACT_DRIVE_HIGH: begin
               pin_oe_nxt  = 1'b1;
               pin_val_nxt = 1'b1;
            end
            default: begin
               pin_oe_nxt = 1'b0;
            end
         endcase
      end else if (ctrl_r.supply_enable_drive_enable) begin
         pin_oe_nxt  = 1'b1;
         // Reserved level codes fall back to low, the safer default
         pin_val_nxt = (ctrl_r.supply_enable_level == uefc_pkg::LVL_ACTIVE_HIGH);
      end else begin
         pin_oe_nxt  = 1'b0;
         pin_val_nxt = 1'b0;
      end
   end

   // Pin registers; undriven from reset since supply polarity is unknown
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ext_power_enable_out    <= 1'b0;
         ext_power_enable_oe_out <= 1'b0;
      end else begin
         ext_power_enable_out    <= pin_val_nxt;
         ext_power_enable_oe_out <= pin_oe_nxt;
      end
   end

   // ==========================================================
   // Read decode; unmapped addresses read zero
   always_comb begin
      rdata = uefc_pkg::UNMAPPED_RD;
      case (req.address)
         uefc_pkg::OFS_EXT_POWER_CONTROL: begin
            rdata = ctrl_word;
         end
         uefc_pkg::OFS_FAULT_RAW_STATUS: begin
            rdata[uefc_pkg::POWER_FAULT_BIT] = fault_flag_r;
         end
         uefc_pkg::OFS_FAULT_IRQ_MASK: begin
            rdata[uefc_pkg::POWER_FAULT_BIT] = fault_mask_r;
         end
         uefc_pkg::OFS_FAULT_IRQ_CLEAR: begin
            rdata[uefc_pkg::POWER_FAULT_BIT] = fault_flag_r & fault_mask_r;
         end
         default: begin
            rdata = uefc_pkg::UNMAPPED_RD;
         end
      endcase
   end

endmodule : uefc_top

/* verification/uefc_top_sva.sv */
// Bus handshake and pin timing checks for the power fault controller
`timescale 1ns/1ns
module uefc_top_sva (
   input wire logic                        clk_in,
   input wire logic                        sys_rst_in,
   input wire logic                        avs_read_in,
   input wire logic                        avs_write_in,
   input wire logic [uefc_pkg::DATA_W-1:0] avs_readdata_out,
   input wire logic                        avs_waitrequest_out,
   input wire logic                        ext_power_fault_in,
   input wire logic                        ext_power_enable_out,
   input wire logic                        ext_power_enable_oe_out,
   input wire logic                        irq_out
);
   // ==========================================================
   // Cycles since a write or a fault pin edge; reset counts as recent
   logic [2:0] wr_age_r;
   logic [2:0] pin_age_r;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) wr_age_r <= 3'h0;
      else if (avs_write_in && !avs_waitrequest_out) wr_age_r <= 3'h0;
      else if (wr_age_r != 3'h7) wr_age_r <= wr_age_r + 3'h1;
   end
   // Pin edges seen here, so sync depth in the design is covered
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) pin_age_r <= 3'h0;
      else if ($changed(ext_power_fault_in)) pin_age_r <= 3'h0;
      else if (pin_age_r != 3'h7) pin_age_r <= pin_age_r + 3'h1;
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // ==========================================================
   // Handshake and output causes
   wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low twice");
   answer_next_a: assert property
      ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered next cycle");
   answer_req_a: assert property (!avs_waitrequest_out |-> avs_read_in || avs_write_in)
      else $error("answer without request");
   rdata_hold_a: assert property
      ($changed(avs_readdata_out) |-> $past(avs_read_in && avs_waitrequest_out))
      else $error("read data moved without read");
   oe_cause_a: assert property (
      $changed(ext_power_enable_oe_out) |-> wr_age_r <= 3'h5 || pin_age_r <= 3'h5)
      else $error("drive enable moved without cause");
   en_cause_a: assert property (
      $changed(ext_power_enable_out) |-> wr_age_r <= 3'h5 || pin_age_r <= 3'h5)
      else $error("enable level moved without cause");
   irq_rise_a: assert property (
      $rose(irq_out) |-> wr_age_r <= 3'h5 || pin_age_r <= 3'h5)
      else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq_out) |-> wr_age_r <= 3'h5)
      else $error("irq fell without a write");
endmodule : uefc_top_sva

bind uefc_top uefc_top_sva u_uefc_top_sva (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .ext_power_fault_in(ext_power_fault_in),
   .ext_power_enable_out(ext_power_enable_out),
   .ext_power_enable_oe_out(ext_power_enable_oe_out), .irq_out(irq_out)
);

/* verification/uefc_supply_model.sv */
// Model of the external supply switch and its fault flag pin
`timescale 1ns/1ns
module uefc_supply_model (
   input  wire logic fault_cmd_in,
   input  wire logic fault_high_in,
   input  wire logic en_in,
   input  wire logic oe_in,
   output logic      fault_out,
   output logic      supply_on_out
);
   // Pull-down bias keeps the supply off while the pin floats
   assign supply_on_out = oe_in ? en_in : 1'h0;
   // Flag pin shows the chosen fault level, the other level is idle
   assign fault_out = fault_cmd_in ? fault_high_in : !fault_high_in;
endmodule : uefc_supply_model

/* verification/test_usb_ext_power_fault_ctrl.sv */
// Self-checking bench for the external power fault controller
`timescale 1ns/1ns
module test_usb_ext_power_fault_ctrl;
   localparam logic [11:0] CTL = uefc_pkg::OFS_EXT_POWER_CONTROL;
   localparam logic [11:0] RAW = uefc_pkg::OFS_FAULT_RAW_STATUS;
   localparam logic [11:0] MSK = uefc_pkg::OFS_FAULT_IRQ_MASK;
   localparam logic [11:0] ISC = uefc_pkg::OFS_FAULT_IRQ_CLEAR;
   logic        clk_in = 1'h0;
   logic        sys_rst_in = 1'h1;
   logic [11:0] adr = 12'h0;
   logic        rd = 1'h0;
   logic        wr = 1'h0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdat;
   logic        wreq;
   logic        fpin;
   logic        en;
   logic        oe;
   logic        irq;
   logic        fcmd = 1'h0;
   logic        fhigh = 1'h0;
   logic        sup;
   int          err_count = 0;
   int          checks = 0;
   // Free-running 100 MHz clock
   always #5 clk_in = ~clk_in;
   uefc_top u_uefc_top (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .ext_power_fault_in(fpin),
      .ext_power_enable_out(en), .ext_power_enable_oe_out(oe), .irq_out(irq)
   );
   uefc_supply_model u_uefc_supply_model (
      .fault_cmd_in(fcmd), .fault_high_in(fhigh), .en_in(en), .oe_in(oe),
      .fault_out(fpin), .supply_on_out(sup)
   );
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk_in);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      be <= b;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (wreq !== 1'h0 && n < 20);
      if (n >= 20) err_count++;
      q = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask : bus
   task automatic wrb(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] q;
      bus(1'h1, a, d, b, q);
   endtask : wrb
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, 4'hf, q);
      chk(nm, e, q);
   endtask : rdc
   // Pin state as {drive enable, supply seen}; long enough for the sync path
   task automatic pin(input string nm, input logic [1:0] e);
      repeat (8) @(posedge clk_in);
      chk(nm, {30'h0, e}, {30'h0, oe, sup});
   endtask : pin
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rdc("ctl", CTL, 32'h0);
      rdc("raw", RAW, 32'h0);
      rdc("msk", MSK, 32'h0);
      rdc("isc", ISC, 32'h0);
      rdc("unmapped", 12'h7fc, 32'h0);
      pin("pin rst", 2'h0);
   endtask : t_reset
   task automatic t_drive();
      for (int d = 0; d < 2; d++) begin
         for (int l = 0; l < 4; l++) begin
            wrb(CTL, 32'(d * 4 + l), 4'hf);
            pin("pin drv", d == 1 ? {1'h1, l == 1} : 2'h0);
         end
      end
      // Reserved bit 3 written back as read, every other bit set
      wrb(CTL, 32'hfffffff7, 4'hf);
      rdc("ctl ones", CTL, 32'h377);
      wrb(CTL, 32'h0, 4'he);
      rdc("ctl lanes", CTL, 32'h77);
      // Idle pin counted as a fault above; clear it so later checks start clean
      wrb(CTL, 32'h0, 4'hf);
      wrb(ISC, 32'h1, 4'hf);
      rdc("raw idle", RAW, 32'h0);
   endtask : t_drive
   task automatic t_sense();
      for (int s = 0; s < 2; s++) begin
         wrb(CTL, 32'h5, 4'hf);
         fhigh <= s[0];
         // Drive-low action selected but not enabled, so the pin must stay normal
         wrb(CTL, 32'(32'h215 + s * 32), 4'hf);
         fcmd <= 1'h1;
         pin("pin noact", 2'h3);
         rdc("raw flt", RAW, 32'h1);
         fcmd <= 1'h0;
         wrb(RAW, 32'h1, 4'hf);
         wrb(ISC, 32'h1, 4'he);
         rdc("raw kept", RAW, 32'h1);
         wrb(ISC, 32'h1, 4'hf);
         rdc("raw clr", RAW, 32'h0);
         wrb(CTL, 32'(32'h5 + s * 32), 4'hf);
         fcmd <= 1'h1;
         pin("pin off", 2'h3);
         rdc("raw off", RAW, 32'h0);
         fcmd <= 1'h0;
      end
   endtask : t_sense
   task automatic t_action();
      logic [1:0] ex [4];
      logic       l;
      fhigh <= 1'h1;
      for (int a = 0; a < 4; a++) begin
         l = (a != 3);
         ex = '{{1'h1, l}, 2'h0, 2'h2, 2'h3};
         wrb(CTL, 32'(a * 256 + 32'h74 + l), 4'hf);
         pin("pin norm", {1'h1, l});
         fcmd <= 1'h1;
         pin("pin act", ex[a]);
         fcmd <= 1'h0;
         pin("pin held", ex[a]);
         wrb(ISC, 32'h1, 4'hf);
         pin("pin back", {1'h1, l});
      end
   endtask : t_action
   task automatic t_irq();
      wrb(CTL, 32'h35, 4'hf);
      wrb(MSK, 32'h1, 4'hf);
      rdc("msk set", MSK, 32'h1);
      fcmd <= 1'h1;
      pin("pin irq", 2'h3);
      chk("irq on", 32'h1, {31'h0, irq});
      rdc("isc on", ISC, 32'h1);
      wrb(MSK, 32'h0, 4'hf);
      pin("pin irq", 2'h3);
      chk("irq mask", 32'h0, {31'h0, irq});
      rdc("isc mask", ISC, 32'h0);
      wrb(MSK, 32'h1, 4'hf);
      fcmd <= 1'h0;
      pin("pin irq", 2'h3);
      chk("irq sticky", 32'h1, {31'h0, irq});
      wrb(ISC, 32'h1, 4'hf);
      pin("pin irq", 2'h3);
      chk("irq clr", 32'h0, {31'h0, irq});
   endtask : t_irq
   // ==========================================================
   // Verdict and run control
   task automatic give_verdict();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // Hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #300000;
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      t_reset();
      t_drive();
      t_sense();
      t_action();
      t_irq();
      give_verdict();
   end
endmodule : test_usb_ext_power_fault_ctrl
